// ===== ssdb_top.sv
// SPI status flags, data buffers, AHB-Lite register slave and interrupt.
// Function
// - Set receive-full flag bit 7 when a transfer completes.
// - Clear receive-full only by flags read seeing it set, then data read.
// - Transmit-empty flag bit 5 is high while the transmit buffer has room.
// - Clear transmit-empty by flags read seeing it set, then data write.
// - Ignore data writes not preceded by a flags read with transmit-empty set.
// - Request interrupt while transmit-empty and its enable are both set.
// - Set transmit-empty when a byte moves from buffer into shifter.
// - Idle interface moves a written byte at once; flag back within two cycles.
// - On transfer end, move a queued byte into the shifter and set the flag.
// - With nothing queued at transfer end, flag stays set and nothing moves.
// - Set mode-fault flag bit 4 when master and slave-select goes low.
// - Mode fault only with master, fault enable set and select output off.
// - Clear mode-fault by flags read seeing it set, then control write.
// - Data reads return the receive buffer; writes load the transmit buffer.
// - In master mode a written byte starts a serial transfer.
// - On overrun keep the unread buffer and discard the new byte.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ssdb_top #(
   parameter int WIDTH = 8,
   parameter int HALF = ssdb_pkg::SCLK_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Serial pins
   input wire logic sclkIn,
   output logic sclkOut,
   output logic sclkOe_n,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOe_n,
   input wire logic selectIn_n,
   output logic selectOut_n,
   output logic selectOe_n,
   // Interrupt
   output logic irq
);
   // ==========================================================================
   // Declarations
   logic [ssdb_pkg::ADDR_W-1:0] addr_ff;
   logic wrPend_ff, rdPend_ff, hready_ff;
   logic [31:0] hrdata_ff;
   logic [7:0] ctrl_ff;
   logic [WIDTH-1:0] txBuf_ff, rxBuf_ff;
   logic txQueued_ff, armTx_ff;
   logic rxFull_ff, armRx_ff;
   logic modeFault_ff, armMf_ff;
   logic [ssdb_pkg::IRQ_W-1:0] irqStat_ff, irqEn_ff;
   logic irq_ff;
   logic sclkOe_n_ff, serialOe_n_ff, selOut_n_ff, selOe_n_ff;
   logic linkLevel, linkRise, linkFall, selLevel, dinLevel;
   logic busy, done, shSclk, shOut;
   logic [WIDTH-1:0] shRx;

   function automatic logic hit(input logic [ssdb_pkg::ADDR_W-1:0] a,
                                input logic [ssdb_pkg::ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   // ==========================================================================
   // Pin synchronisers
   ssdb_sync u_link (
      .clk(clk),
      .reset(reset),
      .pinIn(sclkIn),
      .level(linkLevel),
      .rise(linkRise),
      .fall(linkFall)
   );
   ssdb_sync u_sel (
      .clk(clk),
      .reset(reset),
      .pinIn(selectIn_n),
      .level(selLevel),
      .rise(),
      .fall()
   );
   ssdb_sync u_din (
      .clk(clk),
      .reset(reset),
      .pinIn(serialIn),
      .level(dinLevel),
      .rise(),
      .fall()
   );

   // ==========================================================================
   // Bus decode
   wire logic addrPhase = hsel && htrans[1] && hready;
   wire logic rdTake = addrPhase && !hwrite;
   wire logic wrTake = addrPhase && hwrite;
   wire logic rdFlags = rdPend_ff && hit(addr_ff, ssdb_pkg::OFS_FLAGS);
   wire logic rdData = rdPend_ff && hit(addr_ff, ssdb_pkg::OFS_DATA);
   wire logic wrCtrl = wrPend_ff && hit(addr_ff, ssdb_pkg::OFS_CTRL);
   wire logic wrData = wrPend_ff && hit(addr_ff, ssdb_pkg::OFS_DATA);
   wire logic wrIrqClr = wrPend_ff && hit(addr_ff, ssdb_pkg::OFS_IRQ_CLR);
   wire logic wrIrqEn = wrPend_ff && hit(addr_ff, ssdb_pkg::OFS_IRQ_EN);

   // ==========================================================================
   // Control and flag logic
   wire logic isMaster = ctrl_ff[ssdb_pkg::CTL_MST];
   wire logic txEmpty = !txQueued_ff;
   wire logic wrAccept = wrData && armTx_ff;
   // A queued byte moves whenever the shifter is idle, which also covers idle writes.
   wire logic startMove = txQueued_ff && !busy;
   wire logic nxt_txQueued = wrAccept || (txQueued_ff && !startMove);
   wire logic nxt_armTx = (rdFlags && txEmpty) || (armTx_ff && !wrData);
   wire logic clrRx = rdData && armRx_ff;
   // A data read that clears the flag in the very cycle of a new byte lets the new byte in.
   wire logic rxLoad = done && (!rxFull_ff || clrRx);
   wire logic overrun = done && rxFull_ff && !clrRx;
   wire logic nxt_rxFull = rxLoad || (rxFull_ff && !clrRx);
   wire logic nxt_armRx = (rdFlags && rxFull_ff) || (armRx_ff && !rdData);
   wire logic faultGate = isMaster && ctrl_ff[ssdb_pkg::CTL_FDE] &&
                          !ctrl_ff[ssdb_pkg::CTL_SOE];
   wire logic faultSeen = faultGate && !selLevel;
   wire logic clrMf = wrCtrl && armMf_ff;
   wire logic nxt_modeFault = faultSeen || (modeFault_ff && !clrMf);
   wire logic nxt_armMf = (rdFlags && modeFault_ff) || (armMf_ff && !wrCtrl);
   wire logic [7:0] flagsVal = {rxFull_ff, 1'b0, txEmpty, modeFault_ff, 4'h0};

   // ==========================================================================
   // Interrupt
   wire logic [ssdb_pkg::IRQ_W-1:0] irqEvent = {overrun, faultSeen && !modeFault_ff,
                                               startMove, rxLoad};
   wire logic [ssdb_pkg::IRQ_W-1:0] irqClr = wrIrqClr ? hwdata[ssdb_pkg::IRQ_W-1:0] : '0;
   // Events win over a simultaneous clear so none is lost.
   wire logic [ssdb_pkg::IRQ_W-1:0] nxt_irqStat = (irqStat_ff & ~irqClr) | irqEvent;
   wire logic nxt_irq = (|(irqStat_ff & irqEn_ff)) ||
                        (txEmpty && ctrl_ff[ssdb_pkg::CTL_TIE]);

   // ==========================================================================
   // Read mux
   wire logic [7:0] rdByte = hit(addr_ff, ssdb_pkg::OFS_CTRL) ? ctrl_ff :
                             hit(addr_ff, ssdb_pkg::OFS_FLAGS) ? flagsVal :
                             hit(addr_ff, ssdb_pkg::OFS_DATA) ? rxBuf_ff :
                             hit(addr_ff, ssdb_pkg::OFS_IRQ_STAT) ? 8'(irqStat_ff) :
                             hit(addr_ff, ssdb_pkg::OFS_IRQ_EN) ? 8'(irqEn_ff) : 8'h00;
   wire logic [31:0] nxt_hrdata = rdPend_ff ? {24'h00_0000, rdByte} : hrdata_ff;

   // ==========================================================================
   // Bus registers
   // Reads take one wait state so that a read right after a write sees its effect.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_ff <= '0;
         wrPend_ff <= 1'b0;
         rdPend_ff <= 1'b0;
         hready_ff <= 1'b1;
         hrdata_ff <= '0;
      end else begin
         addr_ff <= addrPhase ? haddr[ssdb_pkg::ADDR_W-1:0] : addr_ff;
         wrPend_ff <= wrTake;
         rdPend_ff <= rdTake;
         hready_ff <= !rdTake;
         hrdata_ff <= nxt_hrdata;
      end
   end

   // ==========================================================================
   // Buffers and flags
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= ssdb_pkg::CTRL_RESET;
         txBuf_ff <= ssdb_pkg::DATA_RESET;
         rxBuf_ff <= ssdb_pkg::DATA_RESET;
         txQueued_ff <= 1'b0;
         armTx_ff <= 1'b0;
         rxFull_ff <= 1'b0;
         armRx_ff <= 1'b0;
         modeFault_ff <= 1'b0;
         armMf_ff <= 1'b0;
      end else begin
         ctrl_ff <= wrCtrl ? hwdata[7:0] : ctrl_ff;
         txBuf_ff <= wrAccept ? hwdata[WIDTH-1:0] : txBuf_ff;
         rxBuf_ff <= rxLoad ? shRx : rxBuf_ff;
         txQueued_ff <= nxt_txQueued;
         armTx_ff <= nxt_armTx;
         rxFull_ff <= nxt_rxFull;
         armRx_ff <= nxt_armRx;
         modeFault_ff <= nxt_modeFault;
         armMf_ff <= nxt_armMf;
      end
   end

   // ==========================================================================
   // Interrupt and pin registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqStat_ff <= ssdb_pkg::IRQ_RESET;
         irqEn_ff <= ssdb_pkg::IRQ_RESET;
         irq_ff <= 1'b0;
         sclkOe_n_ff <= 1'b1;
         serialOe_n_ff <= 1'b1;
         selOut_n_ff <= 1'b1;
         selOe_n_ff <= 1'b1;
      end else begin
         irqStat_ff <= nxt_irqStat;
         irqEn_ff <= wrIrqEn ? hwdata[ssdb_pkg::IRQ_W-1:0] : irqEn_ff;
         irq_ff <= nxt_irq;
         sclkOe_n_ff <= !isMaster;
         serialOe_n_ff <= !(isMaster || !selLevel);
         selOut_n_ff <= !busy;
         selOe_n_ff <= !(isMaster && ctrl_ff[ssdb_pkg::CTL_SOE]);
      end
   end

   // ==========================================================================
   // Shift engine
   ssdb_shifter #(
      .WIDTH(WIDTH),
      .HALF(HALF)
   ) u_shift (
      .clk(clk),
      .reset(reset),
      .start(startMove),
      .txByte(txBuf_ff),
      .isMaster(isMaster),
      .slaveSel(!selLevel),
      .linkRise(linkRise),
      .linkFall(linkFall),
      .serialIn(dinLevel),
      .busy(busy),
      .done(done),
      .rxByte(shRx),
      .serialOut(shOut),
      .sclkOut(shSclk)
   );

   assign hrdata = hrdata_ff;
   assign hreadyout = hready_ff;
   assign hresp = 1'b0;
   assign sclkOut = shSclk;
   assign sclkOe_n = sclkOe_n_ff;
   assign serialOut = shOut;
   assign serialOe_n = serialOe_n_ff;
   assign selectOut_n = selOut_n_ff;
   assign selectOe_n = selOe_n_ff;
   assign irq = irq_ff;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   rx_set_a: assert property (done && !rxFull_ff |=> rxFull_ff && rxBuf_ff == $past(shRx))
      else $error("Receive flag or buffer not loaded after transfer.");
   rx_clear_a: assert property ($fell(rxFull_ff) |-> $past(rdData && armRx_ff))
      else $error("Receive flag cleared without the read sequence.");
   tx_clear_a: assert property ($fell(txEmpty) |-> $past(wrAccept))
      else $error("Transmit flag cleared without an accepted write.");
   wr_ignore_a: assert property (wrData && !armTx_ff |=> $stable(txBuf_ff) && !$rose(txQueued_ff))
      else $error("Data write taken without prior flags read.");
   tx_irq_a: assert property (txEmpty && ctrl_ff[ssdb_pkg::CTL_TIE] |=> irq)
      else $error("Transmit interrupt missing.");
   idle_move_a: assert property (wrAccept && !busy |-> ##[1:2] (txEmpty && busy))
      else $error("Idle write not moved to shifter within two cycles.");
   end_move_a: assert property ($fell(busy) && txQueued_ff |=> busy && txEmpty)
      else $error("Queued byte not moved after transfer end.");
   no_move_a: assert property (done && txEmpty |=> txEmpty)
      else $error("Transmit flag dropped with nothing queued.");
   fault_gate_a: assert property ($rose(modeFault_ff) |-> $past(faultGate && !selLevel))
      else $error("Mode fault set outside the enabled configuration.");
   fault_clr_a: assert property ($fell(modeFault_ff) |-> $past(wrCtrl && armMf_ff))
      else $error("Mode fault cleared without the clear sequence.");
   overrun_a: assert property (overrun |=> $stable(rxBuf_ff) && rxFull_ff)
      else $error("Unread receive byte overwritten.");
endmodule

// ===== ssdb_pkg.sv
// Register map, field positions, reset values and timing of the SPI status and data block.
package ssdb_pkg;
   // ==========================================================================
   // Register map
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_FLAGS = 5'h04;
   localparam logic [4:0] OFS_DATA = 5'h08;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
   localparam logic [4:0] OFS_IRQ_EN = 5'h14;
   // ==========================================================================
   // Fields of serial_port_control_one
   localparam int CTL_FDE = 0;
   localparam int CTL_SOE = 1;
   localparam int CTL_MST = 4;
   localparam int CTL_TIE = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // ==========================================================================
   // Fields of serial_port_flags
   localparam int FLG_RXF = 7;
   localparam int FLG_TXE = 5;
   localparam int FLG_MF = 4;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // ==========================================================================
   // Interrupt status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TXE = 1;
   localparam int IRQ_MF = 2;
   localparam int IRQ_OVR = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   // ==========================================================================
   // Timing
   localparam int CLK_NS = 100;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================================
   // Shifter states
   typedef enum logic [1:0] {
      SH_IDLE = 2'b01,
      SH_RUN = 2'b10
   } ssdb_shstate_e;
endpackage

// ===== ssdb_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
module ssdb_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pin side
   input wire logic pinIn,
   // Synchronised side
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_ff, s2_ff, s3_ff, level_ff;
   wire logic agree = (s2_ff == s3_ff);
   wire logic change = agree && (s3_ff != level_ff);
   // The level resets high because all pins watched here idle high or are ignored when low.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         level_ff <= 1'b1;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         level_ff <= change ? s3_ff : level_ff;
      end
   end
   assign level = level_ff;
   // Edge pulses are not registered: a slave must shift its next bit before the far master samples.
   assign rise = change && s3_ff;
   assign fall = change && !s3_ff;
endmodule

// ===== ssdb_shifter.sv
// Byte shift engine: master clock generation or slave edge following.
`timescale 1ns/1ps
module ssdb_shifter #(
   parameter int WIDTH = 8,
   parameter int HALF = ssdb_pkg::SCLK_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic start,
   input wire logic [WIDTH-1:0] txByte,
   input wire logic isMaster,
   input wire logic slaveSel,
   input wire logic linkRise,
   input wire logic linkFall,
   input wire logic serialIn,
   // Status
   output logic busy,
   output logic done,
   output logic [WIDTH-1:0] rxByte,
   output logic serialOut,
   output logic sclkOut
);
   localparam int CW = $clog2(WIDTH + 1);
   localparam int DW = $clog2(HALF + 1);
   ssdb_pkg::ssdb_shstate_e state_ff;
   logic [WIDTH-1:0] txSh_ff, rxSh_ff, rxByte_ff;
   logic [CW-1:0] cnt_ff;
   logic [DW-1:0] div_ff;
   logic sclk_ff, done_ff;
   wire logic run = (state_ff == ssdb_pkg::SH_RUN);
   wire logic tick = run && isMaster && (div_ff == DW'(HALF - 1));
   // As master the input bit is taken at the falling edge, half a period late, because it
   // reaches the shifter through the pin synchroniser; HALF must therefore be 3 or more.
   wire logic sample = isMaster ? (tick && sclk_ff) : (run && slaveSel && linkRise);
   wire logic shift = isMaster ? (tick && sclk_ff) : (run && slaveSel && linkFall);
   wire logic [CW-1:0] cntNext = sample ? cnt_ff + CW'(1) : cnt_ff;
   wire logic [WIDTH-1:0] rxNext = sample ? {rxSh_ff[WIDTH-2:0], serialIn} : rxSh_ff;
   wire logic last = (cntNext == CW'(WIDTH));
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= ssdb_pkg::SH_IDLE;
         txSh_ff <= '0;
         rxSh_ff <= '0;
         rxByte_ff <= '0;
         cnt_ff <= '0;
         div_ff <= '0;
         sclk_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= shift && last;
         div_ff <= (!run || tick) ? '0 : div_ff + DW'(1);
         sclk_ff <= tick ? !sclk_ff : (run && sclk_ff);
         rxSh_ff <= rxNext;
         cnt_ff <= cntNext;
         case (state_ff)
            ssdb_pkg::SH_IDLE: begin
               if (start) begin
                  txSh_ff <= txByte;
                  cnt_ff <= '0;
                  state_ff <= ssdb_pkg::SH_RUN;
               end
            end
            ssdb_pkg::SH_RUN: begin
               if (shift && last) begin
                  rxByte_ff <= rxNext;
                  state_ff <= ssdb_pkg::SH_IDLE;
               end else if (shift) begin
                  txSh_ff <= {txSh_ff[WIDTH-2:0], 1'b0};
               end
            end
            default: state_ff <= ssdb_pkg::SH_IDLE;
         endcase
      end
   end
   assign busy = run;
   assign done = done_ff;
   assign rxByte = rxByte_ff;
   assign serialOut = txSh_ff[WIDTH-1];
   assign sclkOut = sclk_ff;
endmodule

// ===== ssdb_partner.sv
// Behavioural far-side serial device that answers as a slave or clocks the link as a master.
`timescale 1ns/1ps
module ssdb_partner #(
   parameter logic [7:0] REPLY = 8'hC3
) (
   // Link pins as seen on the wire
   input wire logic sclk,
   input wire logic select_n,
   input wire logic fromDut,
   output logic toDut,
   // Pins driven while this side is master
   output logic sclkDrv,
   output logic selectDrv_n,
   // Observation
   output logic [7:0] rxByte,
   output logic [7:0] frames
);
   logic [7:0] shiftReg;
   logic [7:0] rxShift;
   logic [3:0] bitCnt;
   initial begin
      sclkDrv = 1'b0;
      selectDrv_n = 1'b1;
      shiftReg = REPLY;
      rxShift = 8'h00;
      rxByte = 8'h00;
      bitCnt = 4'h0;
      frames = 8'h00;
   end
   // ==========================================================================
   // Slave data path
   // A deselected device does not hold its bit, so the inverse is shown to expose stale sampling.
   assign toDut = select_n ? ~shiftReg[7] : shiftReg[7];
   always @(negedge select_n) begin
      shiftReg = REPLY ^ frames;
      bitCnt = 4'h0;
   end
   always @(posedge sclk) begin
      if (!select_n) begin
         rxShift = {rxShift[6:0], fromDut};
         bitCnt = bitCnt + 4'h1;
      end
   end
   // The eighth falling edge closes a byte; the next reply goes out at once for back-to-back bytes.
   always @(negedge sclk) begin
      if (!select_n && bitCnt == 4'h8) begin
         rxByte = rxShift;
         frames = frames + 8'h01;
         shiftReg = REPLY ^ frames;
         bitCnt = 4'h0;
      end else if (!select_n) begin
         shiftReg = {shiftReg[6:0], 1'b0};
      end
   end
   // ==========================================================================
   // Master side
   // A second master pulling select low is what the mode-fault logic must catch.
   task automatic hold_select(input logic level);
      selectDrv_n <= level;
   endtask
   // The frame starts off the bench clock grid, so the link phase is unrelated to it.
   task automatic master_byte();
      #137;
      selectDrv_n = 1'b0;
      #400;
      repeat (8) begin
         sclkDrv = 1'b1;
         #400;
         sclkDrv = 1'b0;
         #400;
      end
      selectDrv_n = 1'b1;
   endtask
endmodule

// ===== tb_spi_status_and_data_buffers.sv
// Self-checking bench for the SPI status flags, data buffers and register slave.
`timescale 1ns/1ps
module tb_spi_status_and_data_buffers;
   localparam logic [7:0] MST = 8'h01 << ssdb_pkg::CTL_MST;
   localparam logic [7:0] FDE = 8'h01 << ssdb_pkg::CTL_FDE;
   localparam logic [7:0] SOE = 8'h01 << ssdb_pkg::CTL_SOE;
   localparam logic [7:0] TIE = 8'h01 << ssdb_pkg::CTL_TIE;
   localparam logic [7:0] TXE = 8'h01 << ssdb_pkg::FLG_TXE;
   localparam logic [7:0] RXF = 8'h01 << ssdb_pkg::FLG_RXF;
   localparam logic [7:0] MFF = 8'h01 << ssdb_pkg::FLG_MF;
   localparam logic [7:0] REPLY = 8'hC3;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout, hresp, sclkOut, sclkOe_n, serialIn, serialOut, serialOe_n;
   logic selectOut_n, selectOe_n, irq, sclkDrv, selectDrv_n, sclkWire, selectWire_n;
   logic [7:0] partnerRx;
   logic [7:0] partnerFrames;
   int fails = 0;
   int checked = 0;
   always #50 clk = ~clk;
   // The enabled driver owns the clock and select pins; otherwise the partner's level is on the wire.
   assign sclkWire = sclkOe_n ? sclkDrv : sclkOut;
   assign selectWire_n = selectOe_n ? selectDrv_n : selectOut_n;
   ssdb_top #(.HALF(4)) u_dut (
      .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclkIn(sclkWire),
      .sclkOut(sclkOut), .sclkOe_n(sclkOe_n), .serialIn(serialIn), .serialOut(serialOut),
      .serialOe_n(serialOe_n), .selectIn_n(selectWire_n), .selectOut_n(selectOut_n),
      .selectOe_n(selectOe_n), .irq(irq));
   ssdb_partner #(.REPLY(REPLY)) u_partner (
      .sclk(sclkWire), .select_n(selectWire_n), .fromDut(serialOut), .toDut(serialIn),
      .sclkDrv(sclkDrv), .selectDrv_n(selectDrv_n), .rxByte(partnerRx),
      .frames(partnerFrames));
   // ==========================================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic [4:0] addr, input logic wr, input logic [7:0] wdata);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {27'h000_0000, addr};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wdata};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [4:0] addr, input logic [7:0] exp, input string what);
      bus(addr, 1'b0, 8'h00);
      check(what, rd, 32'(exp));
   endtask
   // Polling the event register leaves the flag sequences untouched.
   task automatic wait_stat(input int bitPos);
      int n;
      n = 0;
      rd = 32'h0000_0000;
      while (rd[bitPos] !== 1'b1 && n < 300) begin
         bus(ssdb_pkg::OFS_IRQ_STAT, 1'b0, 8'h00);
         n++;
      end
      check("event wait", 32'(rd[bitPos]), 32'h0000_0001);
   endtask
   task automatic results();
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      check("irq at reset", 32'(irq), 32'h0000_0000);
      check("response", 32'(hresp), 32'h0000_0000);
      rdchk(ssdb_pkg::OFS_DATA, ssdb_pkg::DATA_RESET, "data reset");
      rdchk(5'h18, 8'h00, "unmapped read");
   endtask
   task automatic t_master();
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | SOE);
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "flags idle");
      check("data pin enable", 32'(serialOe_n), 32'h0000_0000);
      bus(ssdb_pkg::OFS_DATA, 1'b1, 8'hA5);
      bus(ssdb_pkg::OFS_DATA, 1'b1, 8'h77);
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "flag back after move");
      bus(ssdb_pkg::OFS_DATA, 1'b1, 8'h3C);
      rdchk(ssdb_pkg::OFS_FLAGS, 8'h00, "buffer queued");
      bus(ssdb_pkg::OFS_DATA, 1'b1, 8'h55);
      wait_stat(ssdb_pkg::IRQ_RX);
      check("first byte on wire", 32'(partnerRx), 32'h0000_00A5);
      bus(ssdb_pkg::OFS_IRQ_CLR, 1'b1, 8'h01 << ssdb_pkg::IRQ_RX);
      wait_stat(ssdb_pkg::IRQ_OVR);
      check("queued byte on wire", 32'(partnerRx), 32'h0000_003C);
      check("byte count", 32'(partnerFrames), 32'h0000_0002);
      rdchk(ssdb_pkg::OFS_DATA, REPLY, "overrun keeps old");
      rdchk(ssdb_pkg::OFS_FLAGS, RXF | TXE, "full without armed read");
      rdchk(ssdb_pkg::OFS_DATA, REPLY, "data read");
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "full cleared");
   endtask
   task automatic t_irq();
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | SOE | TIE);
      repeat (3) @(posedge clk);
      check("empty request", 32'(irq), 32'h0000_0001);
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | SOE);
      repeat (3) @(posedge clk);
      check("request masked", 32'(irq), 32'h0000_0000);
      bus(ssdb_pkg::OFS_IRQ_EN, 1'b1, 8'h01 << ssdb_pkg::IRQ_TXE);
      repeat (3) @(posedge clk);
      check("event request", 32'(irq), 32'h0000_0001);
      rdchk(ssdb_pkg::OFS_IRQ_EN, 8'h01 << ssdb_pkg::IRQ_TXE, "enable readback");
      bus(ssdb_pkg::OFS_IRQ_CLR, 1'b1, 8'h0F);
      repeat (3) @(posedge clk);
      check("request cleared", 32'(irq), 32'h0000_0000);
      rdchk(ssdb_pkg::OFS_IRQ_STAT, 8'h00, "events cleared");
      bus(ssdb_pkg::OFS_IRQ_EN, 1'b1, 8'h00);
   endtask
   task automatic t_fault();
      logic [7:0] gates [3];
      gates = '{FDE, MST, MST | FDE | SOE};
      for (int i = 0; i < 3; i++) begin
         bus(ssdb_pkg::OFS_CTRL, 1'b1, gates[i]);
         u_partner.hold_select(1'b0);
         repeat (8) @(posedge clk);
         rdchk(ssdb_pkg::OFS_FLAGS, TXE, "fault gated off");
         u_partner.hold_select(1'b1);
         repeat (8) @(posedge clk);
      end
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | FDE);
      u_partner.hold_select(1'b0);
      repeat (8) @(posedge clk);
      u_partner.hold_select(1'b1);
      repeat (8) @(posedge clk);
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | FDE);
      rdchk(ssdb_pkg::OFS_FLAGS, TXE | MFF, "fault held");
      rdchk(ssdb_pkg::OFS_IRQ_STAT, 8'h01 << ssdb_pkg::IRQ_MF, "fault event");
      bus(ssdb_pkg::OFS_CTRL, 1'b1, MST | FDE);
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "fault cleared");
   endtask
   task automatic t_slave();
      bus(ssdb_pkg::OFS_CTRL, 1'b1, 8'h00);
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "slave idle");
      check("data pin released", 32'(serialOe_n), 32'h0000_0001);
      bus(ssdb_pkg::OFS_DATA, 1'b1, 8'h5A);
      u_partner.master_byte();
      repeat (10) @(posedge clk);
      check("slave byte on wire", 32'(partnerRx), 32'h0000_005A);
      rdchk(ssdb_pkg::OFS_FLAGS, RXF | TXE, "slave flags");
      rdchk(ssdb_pkg::OFS_DATA, REPLY ^ 8'h02, "slave received");
      rdchk(ssdb_pkg::OFS_FLAGS, TXE, "slave full cleared");
   endtask
   // ==========================================================================
   // Sequence and watchdog
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_master();
      t_irq();
      t_fault();
      t_slave();
      results();
   end
   initial begin
      #(ssdb_pkg::CLK_NS * 30000);
      fails++;
      results();
   end
endmodule
